// file: rtl/dswf_top.sv
/*
 * Drive status word formatter: assembles the internal 32-bit drive status
 * word from state flags and presents a 16-bit fieldbus status word in the
 * converted layout (profile A) or the direct layout (profile B).
 * Assumes flags, speeds, location and profile select come from logic on
 * ref_clk, while the run enable arrives asynchronously on a pin.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Profile A converts, never forwards directly
// - A bits 0-2: ready, operate, operation_run_enable_active
// - A bits 3-7: fault, offs, inhibit, alarm
// - A bit 8: error within 10 percent
// - A bit 9: remote when external location
// - A bit 10: speed magnitude at or above limit
// - A bits 11-14 application, 15 reserved
// - Profile B copies internal bits 0-15
// - B bits 0-1: start ready, run enable
// - B bit 2 reserved, bit 3 modulating
// - B bit 4: standstill at zero speed
// - B bits 5-6: speeding up, slowing down
// - B bits 7-8: on target, limited
// - B bit 9: supervised value above limit
// - B bits 10-11: backward reference, running
// - B bits 12-13: keypad, bus own control
// - B bit 14: second external location
// - B bit 15: drive faulted
// - Only low sixteen bits reach fieldbus
module dswf_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Layout selection
    input wire dswf_pkg::dswf_profile_e profile_sel,
    // Drive state
    input wire dswf_pkg::dswf_flags_s flags,
    input wire dswf_pkg::dswf_speed_s speeds,
    input wire dswf_pkg::dswf_location_e location,
    // External run enable pin, asynchronous
    input wire logic run_enable_pin,
    // Fieldbus status word and full internal word
    output logic [15:0] fb_status_word_q,
    output logic [31:0] drive_status_q
);

    // Filtered run enable level
    logic run_enable_active;

    // Signed speed arithmetic, one bit wider to avoid overflow
    logic signed [16:0] speed_err;
    logic [16:0] err_mag;
    logic [16:0] act_mag;
    logic [31:0] err_scaled;
    logic [31:0] tol_scaled;

    // Derived conditions
    logic on_target;
    logic over_limit;
    logic remote;

    // Assembled words
    logic [31:0] drive_word;
    logic [15:0] profile_a_word;
    logic [15:0] profile_b_word;

    // Register next values
    logic [15:0] fb_status_word_d;
    logic [31:0] drive_status_d;

    // The pin crosses in through three synchroniser flops and a filter flop before use
    dswf_pin_sync dswf_pin_sync_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(run_enable_pin),
        .level_q(run_enable_active)
    );

    // Speed error and magnitudes
    always_comb begin
        speed_err = 17'({speeds.actual_speed[15], speeds.actual_speed})
            - 17'({speeds.reference_speed[15], speeds.reference_speed});
        // Negate negative values; 17 bits hold the largest magnitude
        if (speed_err[16]) begin
            err_mag = 17'(-speed_err);
        end else begin
            err_mag = 17'(speed_err);
        end
        if (speeds.actual_speed[15]) begin
            act_mag = 17'(-{speeds.actual_speed[15], speeds.actual_speed});
        end else begin
            act_mag = {1'b0, speeds.actual_speed};
        end
    end

    // Tolerance window and supervision check
    always_comb begin
        // tolerance window
        // Compare err*100 against nom*10; no divider needed
        err_scaled = 32'(err_mag) * dswf_pkg::PCT_SCALE;
        tol_scaled = 32'(speeds.nominal_speed) * dswf_pkg::ON_TARGET_PCT;
        on_target = (err_scaled <= tol_scaled);
        // either rotation direction
        // Magnitude used, so reverse running trips the limit too
        over_limit = (act_mag >= {1'b0, speeds.supervision_limit});
        remote = (location == dswf_pkg::DSWF_LOC_FIRST_EXT)
            || (location == dswf_pkg::DSWF_LOC_SECOND_EXT);
    end

    // Internal 32-bit drive status word
    always_comb begin
        drive_word = dswf_pkg::DRV_RESET;
        drive_word[dswf_pkg::B_START_READY] = flags.start_ready;
        drive_word[dswf_pkg::B_RUN_ENABLE] = run_enable_active;
        drive_word[dswf_pkg::B_RESERVED] = 1'b0;
        drive_word[dswf_pkg::B_MODULATING] = flags.modulating;
        drive_word[dswf_pkg::B_STANDSTILL] = flags.standstill;
        drive_word[dswf_pkg::B_SPEEDING_UP] = flags.speeding_up;
        drive_word[dswf_pkg::B_SLOWING_DOWN] = flags.slowing_down;
        drive_word[dswf_pkg::B_ON_TARGET] = on_target;
        drive_word[dswf_pkg::B_LIMITED] = flags.operation_limited;
        drive_word[dswf_pkg::B_THRESHOLD] = flags.threshold_exceeded;
        drive_word[dswf_pkg::B_BACK_REF] = flags.backward_reference;
        drive_word[dswf_pkg::B_BACK_RUN] = flags.backward_running;
        drive_word[dswf_pkg::B_KEYPAD_OWNS] = flags.keypad_owns_control;
        drive_word[dswf_pkg::B_BUS_OWNS] = flags.bus_owns_control;
        drive_word[dswf_pkg::B_SECOND_EXT] = (location == dswf_pkg::DSWF_LOC_SECOND_EXT);
        drive_word[dswf_pkg::B_FAULT] = flags.fault_flag;
        // Upper half: alarm, application bits, control request
        drive_word[dswf_pkg::D_ALARM] = flags.alarm;
        drive_word[dswf_pkg::D_APP_LSB +: dswf_pkg::APP_W] = flags.app_bits;
        drive_word[dswf_pkg::D_CTRL_REQ] = flags.control_request;
    end

    // Direct layout: low half of the internal word
    always_comb begin
        profile_b_word = drive_word[15:0];
    end

    // Converted layout
    always_comb begin
        profile_a_word = dswf_pkg::FB_RESET;
        profile_a_word[dswf_pkg::A_SWITCH_ON_READY] = flags.switch_on_ready;
        profile_a_word[dswf_pkg::A_OPERATE_READY] = flags.operate_ready & ~flags.first_off_active;
        profile_a_word[dswf_pkg::A_OPERATION_RUN_ENABLE_ACTIVE] = flags.operation_run_enable_active;
        profile_a_word[dswf_pkg::A_FAULT] = flags.fault_flag;
        profile_a_word[dswf_pkg::A_SECOND_OFF_IDLE] = ~flags.second_off_active;
        profile_a_word[dswf_pkg::A_THIRD_OFF_IDLE] = ~flags.third_off_active;
        profile_a_word[dswf_pkg::A_SWITCH_ON_INHIBITED] = flags.switch_on_inhibited;
        profile_a_word[dswf_pkg::A_ALARM] = flags.alarm;
        profile_a_word[dswf_pkg::A_ON_TARGET] = on_target;
        profile_a_word[dswf_pkg::A_REMOTE] = remote;
        profile_a_word[dswf_pkg::A_OVER_LIMIT] = over_limit;
        profile_a_word[dswf_pkg::A_APP_LSB +: dswf_pkg::APP_W] = flags.app_bits;
        profile_a_word[dswf_pkg::A_RESERVED] = 1'b0;
    end

    // Output selection
    always_comb begin
        drive_status_d = drive_word;
        if (profile_sel == dswf_pkg::DSWF_PROFILE_B) begin
            fb_status_word_d = profile_b_word;
        end else begin
            fb_status_word_d = profile_a_word;
        end
    end

    // Output registers; one cycle from the ref_clk inputs to the word, the pin adds its synchroniser stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fb_status_word_q <= dswf_pkg::FB_RESET;
            drive_status_q <= dswf_pkg::DRV_RESET;
        end else begin
            fb_status_word_q <= fb_status_word_d;
            drive_status_q <= drive_status_d;
        end
    end

    // Checks on the registered words

    a_reset_clears_word: assert property (@(posedge ref_clk)
        rst |=> (fb_status_word_q == 16'h0000))
        else $error("status word not zero after reset");

    a_copy_low_half: assert property (@(posedge ref_clk) disable iff (rst)
        (profile_sel == dswf_pkg::DSWF_PROFILE_B) |=> (fb_status_word_q == drive_status_q[15:0]))
        else $error("profile B word differs from internal low half");

    a_reserved_a_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (profile_sel == dswf_pkg::DSWF_PROFILE_A) |=> !fb_status_word_q[15])
        else $error("profile A reserved bit set");

    a_reserved_b_zero: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 !drive_status_q[2])
        else $error("internal reserved bit set");

    a_first_off_ready: assert property (@(posedge ref_clk) disable iff (rst)
        (profile_sel == dswf_pkg::DSWF_PROFILE_A) && flags.first_off_active
        |=> !fb_status_word_q[1])
        else $error("operate ready shown during first off");

    a_fault_shown_a: assert property (@(posedge ref_clk) disable iff (rst)
        (profile_sel == dswf_pkg::DSWF_PROFILE_A) |=> (fb_status_word_q[3] == $past(flags.fault_flag)))
        else $error("profile A fault bit wrong");

    a_remote_location: assert property (@(posedge ref_clk) disable iff (rst)
        (profile_sel == dswf_pkg::DSWF_PROFILE_A) && (location == dswf_pkg::DSWF_LOC_LOCAL)
        |=> !fb_status_word_q[9])
        else $error("remote bit set under local control");

    a_reverse_limit: assert property (@(posedge ref_clk) disable iff (rst)
        (profile_sel == dswf_pkg::DSWF_PROFILE_A) && (speeds.actual_speed == -16'sd100)
        && (speeds.supervision_limit == 16'h0064) |=> fb_status_word_q[10])
        else $error("limit bit missed at reverse speed");

    a_on_target_equal: assert property (@(posedge ref_clk) disable iff (rst)
        (speeds.actual_speed == speeds.reference_speed) |=> drive_status_q[7])
        else $error("on target clear with zero error");

    a_run_enable_high: assert property (@(posedge ref_clk) disable iff (rst)
        run_enable_pin [*6] |=> drive_status_q[1])
        else $error("run enable not shown after stable high pin");

    a_run_enable_low: assert property (@(posedge ref_clk) disable iff (rst)
        (!run_enable_pin) [*6] |=> !drive_status_q[1])
        else $error("run enable shown after stable low pin");

    a_second_ext_bit: assert property (@(posedge ref_clk) disable iff (rst)
        (location == dswf_pkg::DSWF_LOC_FIRST_EXT) |=> !drive_status_q[14])
        else $error("second location bit set under first location");

endmodule : dswf_top

`default_nettype wire

// file: include/dswf_pkg.sv
/*
 * Shared definitions for the drive status word formatter: bit positions
 * of both fieldbus layouts and of the internal drive status word, profile
 * and location encodings, the input flag carrier and the tolerance figures.
 * Assumes it is compiled before every design file that names it.
 */
`default_nettype none

package dswf_pkg;

    // Word widths
    localparam int unsigned FB_W = 16;
    localparam int unsigned DRV_W = 32;
    localparam int unsigned APP_W = 4;
    localparam logic [15:0] FB_RESET = 16'h0000;
    localparam logic [31:0] DRV_RESET = 32'h0000_0000;

    // Converted layout (profile A) bit positions
    localparam int unsigned A_SWITCH_ON_READY = 0;
    localparam int unsigned A_OPERATE_READY = 1;
    localparam int unsigned A_OPERATION_RUN_ENABLE_ACTIVE = 2;
    localparam int unsigned A_FAULT = 3;
    localparam int unsigned A_SECOND_OFF_IDLE = 4;
    localparam int unsigned A_THIRD_OFF_IDLE = 5;
    localparam int unsigned A_SWITCH_ON_INHIBITED = 6;
    localparam int unsigned A_ALARM = 7;
    localparam int unsigned A_ON_TARGET = 8;
    localparam int unsigned A_REMOTE = 9;
    localparam int unsigned A_OVER_LIMIT = 10;
    localparam int unsigned A_APP_LSB = 11;
    localparam int unsigned A_RESERVED = 15;

    // Internal drive status word bit positions (profile B copies 0..15)
    localparam int unsigned B_START_READY = 0;
    localparam int unsigned B_RUN_ENABLE = 1;
    localparam int unsigned B_RESERVED = 2;
    localparam int unsigned B_MODULATING = 3;
    localparam int unsigned B_STANDSTILL = 4;
    localparam int unsigned B_SPEEDING_UP = 5;
    localparam int unsigned B_SLOWING_DOWN = 6;
    localparam int unsigned B_ON_TARGET = 7;
    localparam int unsigned B_LIMITED = 8;
    localparam int unsigned B_THRESHOLD = 9;
    localparam int unsigned B_BACK_REF = 10;
    localparam int unsigned B_BACK_RUN = 11;
    localparam int unsigned B_KEYPAD_OWNS = 12;
    localparam int unsigned B_BUS_OWNS = 13;
    localparam int unsigned B_SECOND_EXT = 14;
    localparam int unsigned B_FAULT = 15;
    localparam int unsigned D_ALARM = 16;
    localparam int unsigned D_APP_LSB = 22;
    localparam int unsigned D_CTRL_REQ = 26;

    // Setpoint tolerance: error at most 10 % of nominal speed
    localparam logic [31:0] ON_TARGET_PCT = 32'h0000_000a;
    localparam logic [31:0] PCT_SCALE = 32'h0000_0064;

    // Output layout selection
    typedef enum logic {
        DSWF_PROFILE_A,
        DSWF_PROFILE_B
    } dswf_profile_e;

    // Active control location
    typedef enum logic [1:0] {
        DSWF_LOC_LOCAL,
        DSWF_LOC_FIRST_EXT,
        DSWF_LOC_SECOND_EXT
    } dswf_location_e;

    // State flags from the drive logic, all on ref_clk
    typedef struct packed {
        logic switch_on_ready;
        logic operate_ready;
        logic first_off_active;
        logic operation_run_enable_active;
        logic fault_flag;
        logic second_off_active;
        logic third_off_active;
        logic switch_on_inhibited;
        logic alarm;
        logic start_ready;
        logic modulating;
        logic standstill;
        logic speeding_up;
        logic slowing_down;
        logic operation_limited;
        logic threshold_exceeded;
        logic backward_reference;
        logic backward_running;
        logic keypad_owns_control;
        logic bus_owns_control;
        logic control_request;
        logic [3:0] app_bits;
    } dswf_flags_s;

    // Speed figures for the tolerance and supervision checks
    typedef struct packed {
        logic signed [15:0] actual_speed;
        logic signed [15:0] reference_speed;
        logic [15:0] nominal_speed;
        logic [15:0] supervision_limit;
    } dswf_speed_s;

endpackage : dswf_pkg

`default_nettype wire

// file: rtl/dswf_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one pin level.
 * Assumes the pin is asynchronous to ref_clk and changes slowly compared
 * with a few clock periods.
 */
`timescale 1ns/1ns
`default_nettype none

module dswf_pin_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pin side
    input wire logic pin_in,
    // Filtered level
    output logic level_q
);

    // Stage registers; stage one feeds only stage two
    logic s1_q, s2_q, s3_q;
    logic s1_d, s2_d, s3_d, level_d;

    // Next values: accept a change once stages two and three agree
    always_comb begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            level_q <= level_d;
        end
    end

endmodule : dswf_pin_sync

`default_nettype wire

// file: tb/dswf_bus_master.sv
/*
 * Fieldbus master model: reads the status word on request and hands the
 * captured value back with a one-cycle valid pulse.
 * Assumes the bench raises rd_req just after a falling edge of ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module dswf_bus_master (
    // Clock
    input wire logic ref_clk,
    // Read request from the bench
    input wire logic rd_req,
    // Word presented by the device
    input wire logic [15:0] status_word,
    // Captured reply
    output logic rd_valid,
    output logic [15:0] rd_data
);
    // Sample on the rising edge; idle data is inverted every cycle, so a stale word matches only on alternate cycles
    always_ff @(posedge ref_clk) begin
        rd_valid <= rd_req;
        rd_data <= rd_req ? status_word : ~rd_data;
    end
endmodule : dswf_bus_master

`default_nettype wire

// file: tb/test_drive_status_word_formatter.sv
/*
 * Self-checking bench for the status word formatter: the driver notes the
 * expected word in a queue, a watcher compares each word the master reads.
 * Assumes the package is compiled first and a one-cycle output latency.
 */
`timescale 1ns/1ns
`default_nettype none

module test_drive_status_word_formatter;
    // Clock, reset and design inputs
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    dswf_pkg::dswf_profile_e profile_sel = dswf_pkg::DSWF_PROFILE_A;
    dswf_pkg::dswf_flags_s flags = '0;
    dswf_pkg::dswf_speed_s speeds = '0;
    dswf_pkg::dswf_location_e location = dswf_pkg::DSWF_LOC_LOCAL;
    logic run_enable_pin = 1'b0;
    logic rd_req = 1'b0;
    // Observed outputs
    logic [15:0] fb_status_word_q;
    logic [31:0] drive_status_q;
    logic rd_valid;
    logic [15:0] rd_data;
    // Scoreboard and counters
    logic [15:0] exp_q[$];
    logic [31:0] exp_dq[$];
    logic [15:0] rnd = 16'hc9cd;
    int miscompares = 0;
    int checked = 0;
    // Boundary table: actual, reference, supervision limit
    logic [15:0] tbl[6][3] = '{'{16'h01f4, 16'h0190, 16'h01f4}, '{16'h01f4, 16'h018f, 16'h01f5},
        '{16'hff9c, 16'h0000, 16'h0064}, '{16'hfe0c, 16'hfe0c, 16'h01f4}, '{16'hfe0d, 16'hfe0c, 16'h01f4},
        '{16'h0000, 16'h0065, 16'h0001}};

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    dswf_top dswf_top_inst (.ref_clk(ref_clk), .rst(rst), .profile_sel(profile_sel), .flags(flags),
        .speeds(speeds), .location(location), .run_enable_pin(run_enable_pin),
        .fb_status_word_q(fb_status_word_q), .drive_status_q(drive_status_q));

    dswf_bus_master dswf_bus_master_inst (.ref_clk(ref_clk), .rd_req(rd_req), .status_word(fb_status_word_q),
        .rd_valid(rd_valid), .rd_data(rd_data));

    // Step the pseudo-random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // Word the device should present for the current inputs
    function automatic logic [15:0] exp_word(input logic direct = 1'b0);
        int e;
        int a;
        logic tgt;
        logic over;
        e = int'(speeds.actual_speed) - int'(speeds.reference_speed);
        a = int'(speeds.actual_speed);
        if (e < 0) begin
            e = -e;
        end
        if (a < 0) begin
            a = -a;
        end
        tgt = (e * 100 <= int'(speeds.nominal_speed) * 10);
        over = (a >= int'(speeds.supervision_limit));
        if (profile_sel == dswf_pkg::DSWF_PROFILE_A && !direct) begin
            return {1'b0, flags.app_bits, over, location inside {dswf_pkg::DSWF_LOC_FIRST_EXT,
                dswf_pkg::DSWF_LOC_SECOND_EXT}, tgt, flags.alarm, flags.switch_on_inhibited,
                ~flags.third_off_active, ~flags.second_off_active, flags.fault_flag, flags.operation_run_enable_active,
                flags.operate_ready & ~flags.first_off_active, flags.switch_on_ready};
        end
        return {flags.fault_flag, location == dswf_pkg::DSWF_LOC_SECOND_EXT, flags.bus_owns_control,
            flags.keypad_owns_control, flags.backward_running, flags.backward_reference,
            flags.threshold_exceeded, flags.operation_limited, tgt, flags.slowing_down, flags.speeding_up,
            flags.standstill, flags.modulating, 1'b0, run_enable_pin, flags.start_ready};
    endfunction : exp_word

    // Full internal word the device should hold
    function automatic logic [31:0] exp_drive();
        // low half is the direct layout, upper fields beside it
        return {5'h00, flags.control_request, flags.app_bits, 5'h00, flags.alarm, exp_word(1'b1)};
    endfunction : exp_drive

    // One read by the master, expectation noted first; bounded wait for the reply
    task automatic do_read(input logic [15:0] exp);
        @(negedge ref_clk);
        rd_req = 1'b1;
        exp_q.push_back(exp);
        // Internal word is cleared while reset is held
        exp_dq.push_back(rst ? 32'h0000_0000 : exp_drive());
        @(negedge ref_clk);
        rd_req = 1'b0;
        for (int i = 0; i < 4 && exp_q.size() != 0; i++) begin
            @(posedge ref_clk);
        end
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("[FAIL] read reply expected 1 seen 0");
            summarize();
        end
    endtask : do_read

    // Watcher: each reply is matched against the oldest note
    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1 && exp_q.size() != 0) begin
            checked++;
            if (rd_data !== exp_q[0]) begin
                miscompares++;
                $display("[FAIL] status_word expected %h seen %h", exp_q[0], rd_data);
            end
            void'(exp_q.pop_front());
            checked++;
            if (drive_status_q !== exp_dq[0]) begin
                miscompares++;
                $display("[FAIL] drive_status expected %h seen %h", exp_dq[0], drive_status_q);
            end
            void'(exp_dq.pop_front());
        end
    end

    // Counts and verdict
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (2) @(negedge ref_clk);
        do_read(16'h0000);
        @(negedge ref_clk);
        rst = 1'b0;
        run_enable_pin = 1'b1;
        repeat (8) @(negedge ref_clk);
        $display("test reset done");
        // Tolerance and supervision boundaries in both layouts, all locations
        for (int i = 0; i < 12; i++) begin
            @(negedge ref_clk);
            profile_sel = dswf_pkg::dswf_profile_e'(i / 6);
            location = dswf_pkg::dswf_location_e'(i[1:0]);
            speeds = {tbl[i % 6][0], tbl[i % 6][1], 16'h03e8, tbl[i % 6][2]};
            do_read(exp_word());
        end
        $display("test boundaries done");
        // Random flags, speeds, locations and layouts, pin moved with settle time
        for (int i = 0; i < 240; i++) begin
            @(negedge ref_clk);
            if (i % 40 == 0) begin
                run_enable_pin = rnd[3];
                repeat (8) @(negedge ref_clk);
            end
            rnd = lfsr_next(rnd);
            flags = 25'({rnd, lfsr_next(rnd)});
            rnd = lfsr_next(lfsr_next(rnd));
            profile_sel = dswf_pkg::dswf_profile_e'(rnd[0]);
            location = dswf_pkg::dswf_location_e'(rnd[5:4]);
            speeds = {rnd, lfsr_next(rnd) ^ {7'h00, rnd[8:0]}, lfsr_next(lfsr_next(rnd)), rnd ^ 16'h5a5a};
            rnd = lfsr_next(lfsr_next(rnd));
            if (rnd[1]) begin
                speeds.reference_speed = speeds.actual_speed + 16'(signed'(rnd[7:0]));
            end
            do_read(exp_word());
        end
        $display("test random done");
        // reset in mid-run clears the word
        @(negedge ref_clk);
        rst = 1'b1;
        flags = '1;
        do_read(16'h0000);
        rst = 1'b0;
        $display("test midrun reset done");
        summarize();
    end
endmodule : test_drive_status_word_formatter

`default_nettype wire
